// File: core/pin_mux_params.svh
// constants for the strap-selected programmable function pin mux
// What this block does
// - thirty programmable function pins, numbered 2 to 31, chosen by the mux.
// - two low strap inputs pick one of four default function maps.
// - strap one 200k down/200k up/10k down/10k up picks map one to four.
// - fixed pins keep supply, discharge, port, flash and controller bus roles.
// - map one: pin 19 target bus data, 26 its clock, others general.
// - map two: microphone detect and audio serial lines on 7,14,19,26,27,28.
// - map three: serial port lines on pins 6,7,14,19,26,27,28.
// - pin-mux override registers take precedence over the strap map.
// - overrides accepted from configuration stage or one-time memory before attach.
// - after attach, overrides accepted from target bus or USB commands.
// - straps latched at power-on and external reset rise, held until next reset.
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

`define PIN_FIRST 2
`define NUM_PINS 30
`define PIN_IDX_W 5
`define NUM_FUNCS 43
`define FUNC_W 6
`define STRAP_BITS 4
// strap settle count in cycles after the sync flops are loaded
`define STRAP_SETTLE 8'h03
`define STRAP_CNT_W 8

`endif

// File: core/pin_mux_pkg.sv
// types for the strap-selected programmable function pin mux
package pin_mux_pkg;

   typedef enum logic [1:0] {
      MAP_BUS,
      MAP_AUDIO,
      MAP_SERIAL,
      MAP_GENERAL
   } pin_map_t;

   typedef enum logic [1:0] {
      SRC_CONFIG_STAGE,
      SRC_ONE_TIME_MEM,
      SRC_TARGET_BUS,
      SRC_USB_COMMAND
   } mux_src_t;

   typedef enum logic [5:0] {
      FN_NONE,
      FN_CONN1_SUPPLY_CTL_A,
      FN_CONN1_SUPPLY_CTL_B,
      FN_CONN2_SUPPLY_CTL_A,
      FN_CONN2_SUPPLY_CTL_B,
      FN_CONN1_DISCHARGE,
      FN_CONN2_DISCHARGE,
      FN_PORT1_POWER_CTL,
      FN_PORT2_POWER_CTL,
      FN_PORT3_POWER_CTL,
      FN_PORT3_SUPERSPEED_POWER_CTL,
      FN_PORT4_POWER_CTL,
      FN_FLASH_CHIP_ENABLE_N,
      FN_FLASH_CLOCK,
      FN_FLASH_IO0,
      FN_FLASH_IO1,
      FN_FLASH_IO2,
      FN_FLASH_IO3,
      FN_TARGET_TWOWIRE_DATA,
      FN_TARGET_TWOWIRE_CLOCK,
      FN_CONTROLLER_TWOWIRE_CLOCK,
      FN_CONTROLLER_TWOWIRE_DATA,
      FN_GENERAL_LINE_70,
      FN_GENERAL_LINE_71,
      FN_GENERAL_LINE_78,
      FN_GENERAL_LINE_83,
      FN_GENERAL_LINE_90,
      FN_GENERAL_LINE_91,
      FN_GENERAL_LINE_92,
      FN_GENERAL_LINE_93,
      FN_MICROPHONE_DETECT,
      FN_AUDIO_SERIAL_IN,
      FN_AUDIO_SERIAL_OUT,
      FN_AUDIO_BIT_CLOCK,
      FN_AUDIO_MASTER_CLOCK,
      FN_AUDIO_WORD_SELECT,
      FN_SERIAL_RECEIVE,
      FN_SERIAL_TRANSMIT,
      FN_SERIAL_CLEAR_TO_SEND_N,
      FN_SERIAL_REQUEST_TO_SEND_N,
      FN_SERIAL_SET_READY_N,
      FN_SERIAL_TERMINAL_READY_N,
      FN_SERIAL_CARRIER_DETECT_N
   } pin_func_t;

endpackage : pin_mux_pkg

// File: core/pin_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   // stage1 feeds nothing but sync_o
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule : pin_sync

// File: core/strap_latch.sv
// strap sampling, latching and map decode
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module strap_latch
   import pin_mux_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ext_rst_n_i,
   input wire logic strap1_pull_up_i,
   input wire logic strap1_strong_i,
   input wire logic strap2_pull_up_i,
   input wire logic strap2_strong_i,
   output pin_map_t map_o,
   output logic reserved_o,
   output logic valid_o
);

   // -----------------------------------------------------------------
   // synchronise straps and external reset
   // -----------------------------------------------------------------
   logic [`STRAP_BITS-1:0] strap_s;
   logic ext_rst_n_s;
   logic ext_prev;
   logic [`STRAP_CNT_W-1:0] settle;

   pin_sync #(.WIDTH(`STRAP_BITS + 1)) u_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .async_i({ext_rst_n_i, strap2_pull_up_i, strap2_strong_i,
                strap1_pull_up_i, strap1_strong_i}),
      .sync_o({ext_rst_n_s, strap_s})
   );

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   wire strap2_ok = (strap_s[3:2] == 2'h0);
   wire ext_rise = ext_rst_n_s && !ext_prev;
   wire settle_done = (settle == `STRAP_SETTLE);
   wire capture = settle_done && !valid_o && ext_rst_n_s;
   pin_map_t next_map;

   always_comb begin
      case (strap_s[1:0])
         2'h0: next_map = MAP_BUS;
         2'h2: next_map = MAP_AUDIO;
         2'h1: next_map = MAP_SERIAL;
         2'h3: next_map = MAP_GENERAL;
         default: next_map = MAP_BUS;
      endcase
      if (!strap2_ok) begin
         next_map = MAP_BUS;
      end
   end

   // -----------------------------------------------------------------
   // latch
   // -----------------------------------------------------------------
   // counter restarts at each external reset rise so the sync has settled
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_prev <= 1'b0;
         settle <= '0;
         valid_o <= 1'b0;
         map_o <= MAP_BUS;
         reserved_o <= 1'b0;
      end else begin
         ext_prev <= ext_rst_n_s;
         if (!ext_rst_n_s || ext_rise) begin
            settle <= '0;
            valid_o <= 1'b0;
         end else if (!settle_done) begin
            settle <= settle + `STRAP_CNT_W'(1);
         end
         if (capture) begin
            map_o <= next_map;
            reserved_o <= !strap2_ok;
            valid_o <= 1'b1;
         end
      end
   end

endmodule : strap_latch

// File: core/pin_mux.sv
// programmable function pin multiplexer with strap default maps
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module pin_mux
   import pin_mux_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ext_rst_n_i,
   input wire logic strap1_pull_up_i,
   input wire logic strap1_strong_i,
   input wire logic strap2_pull_up_i,
   input wire logic strap2_strong_i,
   input wire logic hub_attached_i,
   input wire logic mux_wr_i,
   input wire mux_src_t mux_wr_src_i,
   input wire logic [`PIN_IDX_W-1:0] mux_wr_pin_i,
   input wire logic mux_wr_override_i,
   input wire pin_func_t mux_wr_func_i,
   input wire logic [`NUM_FUNCS-1:0] func_out_i,
   input wire logic [`NUM_FUNCS-1:0] func_oe_n_i,
   input wire logic [`NUM_PINS-1:0] prog_func_pins_in_i,
   output logic [`NUM_PINS-1:0] prog_func_pins_out_o,
   output logic [`NUM_PINS-1:0] prog_func_pins_oe_n_o,
   output logic [`NUM_FUNCS-1:0] func_in_o,
   output logic [1:0] active_map_o,
   output logic strap_reserved_o,
   output logic mux_ready_o,
   output logic mux_wr_ack_o,
   output logic mux_wr_refused_o
);

   // -----------------------------------------------------------------
   // default function of one pin in one map
   // -----------------------------------------------------------------
   function automatic pin_func_t default_func(input pin_map_t map,
                                              input int pin);
      pin_func_t f;
      f = FN_NONE;
      case (pin)
         2: f = FN_CONN1_SUPPLY_CTL_A;
         3: f = FN_CONN1_SUPPLY_CTL_B;
         4: f = FN_CONN2_DISCHARGE;
         5: f = FN_CONN1_DISCHARGE;
         10: f = FN_CONN2_SUPPLY_CTL_A;
         11: f = FN_CONN2_SUPPLY_CTL_B;
         12: f = FN_PORT3_SUPERSPEED_POWER_CTL;
         13: f = FN_PORT3_POWER_CTL;
         15: f = FN_PORT2_POWER_CTL;
         16: f = FN_PORT4_POWER_CTL;
         17: f = FN_PORT1_POWER_CTL;
         20: f = FN_FLASH_CHIP_ENABLE_N;
         21: f = FN_FLASH_CLOCK;
         22: f = FN_FLASH_IO0;
         23: f = FN_FLASH_IO1;
         24: f = FN_FLASH_IO2;
         25: f = FN_FLASH_IO3;
         29: f = FN_GENERAL_LINE_93;
         30: f = FN_CONTROLLER_TWOWIRE_CLOCK;
         31: f = FN_CONTROLLER_TWOWIRE_DATA;
         6: begin
            f = (map == MAP_SERIAL) ? FN_SERIAL_RECEIVE
                                    : FN_GENERAL_LINE_70;
         end
         7: begin
            case (map)
               MAP_AUDIO: f = FN_MICROPHONE_DETECT;
               MAP_SERIAL: f = FN_SERIAL_TRANSMIT;
               default: f = FN_GENERAL_LINE_71;
            endcase
         end
         14: begin
            case (map)
               MAP_AUDIO: f = FN_AUDIO_SERIAL_IN;
               MAP_SERIAL: f = FN_SERIAL_CLEAR_TO_SEND_N;
               default: f = FN_GENERAL_LINE_78;
            endcase
         end
         19: begin
            case (map)
               MAP_BUS: f = FN_TARGET_TWOWIRE_DATA;
               MAP_AUDIO: f = FN_AUDIO_SERIAL_OUT;
               MAP_SERIAL: f = FN_SERIAL_REQUEST_TO_SEND_N;
               default: f = FN_GENERAL_LINE_83;
            endcase
         end
         26: begin
            case (map)
               MAP_BUS: f = FN_TARGET_TWOWIRE_CLOCK;
               MAP_AUDIO: f = FN_AUDIO_BIT_CLOCK;
               MAP_SERIAL: f = FN_SERIAL_SET_READY_N;
               default: f = FN_GENERAL_LINE_90;
            endcase
         end
         27: begin
            case (map)
               MAP_AUDIO: f = FN_AUDIO_MASTER_CLOCK;
               MAP_SERIAL: f = FN_SERIAL_TERMINAL_READY_N;
               default: f = FN_GENERAL_LINE_91;
            endcase
         end
         28: begin
            case (map)
               MAP_AUDIO: f = FN_AUDIO_WORD_SELECT;
               MAP_SERIAL: f = FN_SERIAL_CARRIER_DETECT_N;
               default: f = FN_GENERAL_LINE_92;
            endcase
         end
         // pins 8, 9 and 18 carry nothing in any map
         default: f = FN_NONE;
      endcase
      return f;
   endfunction : default_func

   // -----------------------------------------------------------------
   // strap latch and pin input sync
   // -----------------------------------------------------------------
   pin_map_t map;
   logic map_valid;
   logic map_reserved;
   logic [`NUM_PINS-1:0] pin_in_s;

   strap_latch u_strap (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .ext_rst_n_i(ext_rst_n_i),
      .strap1_pull_up_i(strap1_pull_up_i),
      .strap1_strong_i(strap1_strong_i),
      .strap2_pull_up_i(strap2_pull_up_i),
      .strap2_strong_i(strap2_strong_i),
      .map_o(map),
      .reserved_o(map_reserved),
      .valid_o(map_valid)
   );

   pin_sync #(.WIDTH(`NUM_PINS)) u_pin_sync (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .async_i(prog_func_pins_in_i),
      .sync_o(pin_in_s)
   );

   // -----------------------------------------------------------------
   // override registers
   // -----------------------------------------------------------------
   logic [`NUM_PINS-1:0] ovr_en;
   pin_func_t ovr_func [`NUM_PINS];

   wire src_pre_attach = (mux_wr_src_i == SRC_CONFIG_STAGE) ||
                         (mux_wr_src_i == SRC_ONE_TIME_MEM);
   wire src_runtime = (mux_wr_src_i == SRC_TARGET_BUS) ||
                      (mux_wr_src_i == SRC_USB_COMMAND);
   // pre-attach sources lose access once the hub is up, and vice versa
   wire src_ok = hub_attached_i ? src_runtime
                                : src_pre_attach;
   wire pin_ok = (mux_wr_pin_i >= `PIN_IDX_W'(`PIN_FIRST));
   wire func_ok = (mux_wr_func_i <= FN_SERIAL_CARRIER_DETECT_N);
   // writes wait for the ready level that the outside sees
   wire wr_accept = mux_wr_i && map_valid && mux_ready_o && src_ok &&
                    pin_ok && func_ok;
   wire [`PIN_IDX_W-1:0] wr_idx = mux_wr_pin_i - `PIN_IDX_W'(`PIN_FIRST);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ovr_en <= '0;
         mux_wr_ack_o <= 1'b0;
         mux_wr_refused_o <= 1'b0;
      end else begin
         mux_wr_ack_o <= wr_accept;
         mux_wr_refused_o <= mux_wr_i && !wr_accept;
         if (!map_valid) begin
            // an external reset drops every override with the straps
            ovr_en <= '0;
         end else if (wr_accept) begin
            ovr_en[wr_idx] <= mux_wr_override_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (wr_accept) begin
         ovr_func[wr_idx] <= mux_wr_func_i;
      end
   end

   // -----------------------------------------------------------------
   // per pin selection
   // -----------------------------------------------------------------
   pin_func_t sel [`NUM_PINS];

   genvar gp;
   generate
      for (gp = 0; gp < `NUM_PINS; gp++) begin : g_sel
         assign sel[gp] = ovr_en[gp] ? ovr_func[gp]
                          : default_func(map, gp + `PIN_FIRST);
      end
   endgenerate

   // -----------------------------------------------------------------
   // routed pins and function inputs
   // -----------------------------------------------------------------
   logic [`NUM_PINS-1:0] next_out;
   logic [`NUM_PINS-1:0] next_oe_n;
   logic [`NUM_FUNCS-1:0] next_func_in;

   // pins float until the straps have been latched
   always_comb begin
      next_out = '0;
      next_oe_n = '1;
      next_func_in = '0;
      for (int p = 0; p < `NUM_PINS; p++) begin
         if (map_valid && sel[p] != FN_NONE) begin
            next_out[p] = func_out_i[sel[p]];
            next_oe_n[p] = func_oe_n_i[sel[p]];
            next_func_in[sel[p]] = next_func_in[sel[p]] | pin_in_s[p];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prog_func_pins_out_o <= '0;
         prog_func_pins_oe_n_o <= '1;
         func_in_o <= '0;
         active_map_o <= 2'h0;
         strap_reserved_o <= 1'b0;
         mux_ready_o <= 1'b0;
      end else begin
         prog_func_pins_out_o <= next_out;
         prog_func_pins_oe_n_o <= next_oe_n;
         func_in_o <= next_func_in;
         active_map_o <= map;
         strap_reserved_o <= map_reserved;
         mux_ready_o <= map_valid;
      end
   end

endmodule : pin_mux

// File: test/pin_mux_props.sv
// assertion checker for the programmable function pin mux
`timescale 1ns/100ps
`include "pin_mux_params.svh"
module pin_mux_props
   import pin_mux_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic ext_rst_n_i,
   input wire logic hub_attached_i,
   input wire logic mux_wr_i,
   input wire mux_src_t mux_wr_src_i,
   input wire logic [`PIN_IDX_W-1:0] mux_wr_pin_i,
   input wire logic [`NUM_FUNCS-1:0] func_out_i,
   input wire logic [`NUM_FUNCS-1:0] func_oe_n_i,
   input wire logic [`NUM_PINS-1:0] prog_func_pins_out_o,
   input wire logic [`NUM_PINS-1:0] prog_func_pins_oe_n_o,
   input wire logic [1:0] active_map_o,
   input wire logic strap_reserved_o,
   input wire logic mux_ready_o,
   input wire logic mux_wr_ack_o,
   input wire logic mux_wr_refused_o
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic [2:0] ext_high;
   logic pin2_set;
   // pin two override would legally change its routing
   wire [2:0] next_ext_high = !ext_rst_n_i ? 3'h0 :
                              (&ext_high) ? ext_high : ext_high + 3'h1;
   wire next_pin2_set = mux_ready_o & (pin2_set |
                        (mux_wr_i & (mux_wr_pin_i == 5'h02)));
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_high <= 3'h0;
         pin2_set <= 1'b0;
      end else begin
         ext_high <= next_ext_high;
         pin2_set <= next_pin2_set;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence wr_taken;
      mux_wr_i;
   endsequence
   sequence answered;
      mux_wr_ack_o ^ mux_wr_refused_o;
   endsequence
   one_answer_a: assert property (wr_taken |=> answered)
      else $error("write not answered once");
   no_stray_a: assert property (!mux_wr_i |=>
      !mux_wr_ack_o && !mux_wr_refused_o) else $error("stray answer");
   early_write_a: assert property (mux_wr_i && !mux_ready_o
      |=> mux_wr_refused_o) else $error("write before ready taken");
   pin_range_a: assert property (mux_wr_i && mux_wr_pin_i < 5'h02
      |=> mux_wr_refused_o) else $error("pin below two taken");
   runtime_src_a: assert property (mux_wr_i && hub_attached_i &&
      mux_wr_src_i inside {SRC_CONFIG_STAGE, SRC_ONE_TIME_MEM}
      |=> mux_wr_refused_o) else $error("early source taken after attach");
   attach_src_a: assert property (mux_wr_i && !hub_attached_i &&
      mux_wr_src_i inside {SRC_TARGET_BUS, SRC_USB_COMMAND}
      |=> mux_wr_refused_o) else $error("runtime source taken before attach");
   map_held_a: assert property (mux_ready_o && $past(mux_ready_o)
      |-> $stable(active_map_o) && $stable(strap_reserved_o))
      else $error("latched map changed");
   ready_held_a: assert property (mux_ready_o && ext_high == 3'h7
      |=> mux_ready_o) else $error("ready dropped without reset");
   reserved_map_a: assert property (mux_ready_o && strap_reserved_o
      |-> active_map_o == 2'h0) else $error("reserved strap not map one");
   fixed_pin_a: assert property (mux_ready_o && $past(mux_ready_o) &&
      !pin2_set |-> prog_func_pins_out_o[0] == $past(func_out_i[1]) &&
      prog_func_pins_oe_n_o[0] == $past(func_oe_n_i[1]))
      else $error("pin two not on its supply control");
   idle_pins_a: assert property (!mux_ready_o && !$past(mux_ready_o)
      |-> &prog_func_pins_oe_n_o) else $error("pin driven before ready");
endmodule : pin_mux_props
bind pin_mux pin_mux_props props_i (.mclk_i, .nrst_i, .ext_rst_n_i,
   .hub_attached_i, .mux_wr_i, .mux_wr_src_i, .mux_wr_pin_i, .func_out_i,
   .func_oe_n_i, .prog_func_pins_out_o, .prog_func_pins_oe_n_o,
   .active_map_o, .strap_reserved_o, .mux_ready_o, .mux_wr_ack_o,
   .mux_wr_refused_o);

// File: test/board_model.sv
// board straps and pin peripherals around the pin mux
`timescale 1ns/100ps
module board_model (
   input wire logic [1:0] map_sel_i,
   input wire logic strap2_bad_i,
   input wire logic [29:0] pins_out_i,
   input wire logic [29:0] pins_oe_n_i,
   input wire logic [29:0] periph_drive_i,
   input wire logic [29:0] periph_val_i,
   output logic strap1_pull_up_o,
   output logic strap1_strong_o,
   output logic strap2_pull_up_o,
   output logic strap2_strong_o,
   output logic unused_third_strap_o,
   output logic [29:0] pins_in_o
);
   assign strap1_pull_up_o = map_sel_i[0];
   assign strap1_strong_o = map_sel_i[1];
   // a reserved fit is only made when a test asks for it
   assign strap2_pull_up_o = strap2_bad_i;
   assign strap2_strong_o = 1'b0;
   assign unused_third_strap_o = 1'b0;
   // released pins fall to the weak pull-down
   assign pins_in_o = (~pins_oe_n_i & pins_out_i) |
                      (pins_oe_n_i & periph_drive_i & periph_val_i);
endmodule : board_model

// File: test/testbench.sv
// self-checking bench for the programmable function pin mux
`timescale 1ns/100ps
module testbench
   import pin_mux_pkg::*;
;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ext_rst_n_i = 1'b1;
   logic hub_attached_i = 1'b0;
   logic mux_wr_i = 1'b0;
   logic mux_wr_override_i = 1'b0;
   mux_src_t mux_wr_src_i = SRC_CONFIG_STAGE;
   logic [4:0] mux_wr_pin_i = 5'h00;
   pin_func_t mux_wr_func_i = FN_NONE;
   logic [42:0] func_out_i = '0;
   logic [42:0] func_oe_n_i = '1;
   logic [42:0] func_in_o;
   logic [29:0] prog_func_pins_in_i, prog_func_pins_out_o;
   logic [29:0] prog_func_pins_oe_n_o;
   logic [29:0] hot;
   logic [29:0] periph_drive = '0;
   logic [29:0] periph_val = '0;
   logic [1:0] active_map_o;
   logic [1:0] map_sel = 2'h0;
   logic strap2_bad = 1'b0;
   logic strap1_pull_up_i, strap1_strong_i, strap2_pull_up_i;
   logic strap2_strong_i, strap_reserved_o, mux_ready_o;
   logic mux_wr_ack_o, mux_wr_refused_o;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   typedef struct packed {
      logic [1:0] sel;
      logic [1:0] map;
      logic [4:0][5:0] fn;
   } row_t;
   // function codes expected on pins 2, 7, 19, 26 and 30
   localparam row_t rows [4] = '{
      '{2'h0, 2'h0, {6'h14, 6'h13, 6'h12, 6'h17, 6'h01}},
      '{2'h1, 2'h1, {6'h14, 6'h21, 6'h20, 6'h1E, 6'h01}},
      '{2'h2, 2'h2, {6'h14, 6'h28, 6'h27, 6'h25, 6'h01}},
      '{2'h3, 2'h3, {6'h14, 6'h1A, 6'h19, 6'h17, 6'h01}}};
   localparam logic [4:0] pin_no [5] = '{5'h02, 5'h07, 5'h13, 5'h1A, 5'h1E};

   pin_mux uut (.mclk_i, .nrst_i, .ext_rst_n_i, .strap1_pull_up_i,
      .strap1_strong_i, .strap2_pull_up_i, .strap2_strong_i, .hub_attached_i,
      .mux_wr_i, .mux_wr_src_i, .mux_wr_pin_i, .mux_wr_override_i,
      .mux_wr_func_i, .func_out_i, .func_oe_n_i, .prog_func_pins_in_i,
      .prog_func_pins_out_o, .prog_func_pins_oe_n_o, .func_in_o,
      .active_map_o, .strap_reserved_o, .mux_ready_o, .mux_wr_ack_o,
      .mux_wr_refused_o);
   board_model board (.map_sel_i(map_sel), .strap2_bad_i(strap2_bad),
      .pins_out_i(prog_func_pins_out_o), .pins_oe_n_i(prog_func_pins_oe_n_o),
      .periph_drive_i(periph_drive), .periph_val_i(periph_val),
      .strap1_pull_up_o(strap1_pull_up_i), .strap1_strong_o(strap1_strong_i),
      .strap2_pull_up_o(strap2_pull_up_i), .strap2_strong_o(strap2_strong_i),
      .unused_third_strap_o(), .pins_in_o(prog_func_pins_in_i));

   always #2.5 mclk_i = ~mclk_i;
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [42:0] seen,
                        input logic [42:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic wait_ready();
      int n;
      n = 0;
      while (mux_ready_o !== 1'b1 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      check("ready", mux_ready_o, 1'b1);
   endtask : wait_ready
   task automatic restart(input logic [1:0] sel, input logic bad);
      map_sel = sel;
      strap2_bad = bad;
      nrst_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      nrst_i = 1'b1;
      wait_ready();
   endtask : restart
   // an idle cycle follows so the strobe never toggles twice in a step
   task automatic write(input mux_src_t src, input logic [4:0] pin,
                        input logic ovr, input logic [5:0] fn,
                        input logic ack);
      mux_wr_src_i = src;
      mux_wr_pin_i = pin;
      mux_wr_override_i = ovr;
      mux_wr_func_i = pin_func_t'(fn);
      mux_wr_i = 1'b1;
      @(negedge mclk_i);
      mux_wr_i = 1'b0;
      check("ack", mux_wr_ack_o, ack);
      check("refused", mux_wr_refused_o, !ack);
      @(negedge mclk_i);
   endtask : write
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      @(negedge mclk_i);
      check("oe_n in reset", prog_func_pins_oe_n_o, {30{1'b1}});
      check("ready in reset", mux_ready_o, 1'b0);
      foreach (rows[r]) begin
         restart(rows[r].sel, 1'b0);
         check("map", active_map_o, rows[r].map);
         check("reserved", strap_reserved_o, 1'b0);
         func_oe_n_i = '0;
         for (int k = 0; k < 5; k++) begin
            func_out_i = 43'h1 << rows[r].fn[k];
            hot = 30'h1 << (pin_no[k] - 5'h02);
            @(negedge mclk_i);
            // only the one pin on the raised function may go high
            check("pin out", prog_func_pins_out_o,
                  hot);
            // every pin drives except the three without a function
            check("pin oe_n", prog_func_pins_oe_n_o,
                  30'h000100C0);
         end
         check("unused pin", prog_func_pins_oe_n_o[6], 1'b1);
         func_out_i = '0;
         func_oe_n_i = '1;
      end
      map_sel = 2'h1;
      repeat (10) @(negedge mclk_i);
      check("map held", active_map_o, 2'h3);
      ext_rst_n_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      check("ready in ext reset", mux_ready_o, 1'b0);
      ext_rst_n_i = 1'b1;
      wait_ready();
      check("map relatched", active_map_o, 2'h1);
      restart(2'h2, 1'b1);
      check("reserved map", active_map_o, 2'h0);
      check("reserved flag", strap_reserved_o, 1'b1);
      strap2_bad = 1'b0;
      map_sel = 2'h0;
      nrst_i = 1'b0;
      @(negedge mclk_i);
      nrst_i = 1'b1;
      write(SRC_CONFIG_STAGE, 5'h06, 1'b1, 6'h24, 1'b0);
      wait_ready();
      periph_drive = 30'h10;
      periph_val = 30'h10;
      repeat (4) @(negedge mclk_i);
      check("default input", func_in_o[22], 1'b1);
      write(SRC_ONE_TIME_MEM, 5'h06, 1'b1, 6'h24, 1'b1);
      repeat (4) @(negedge mclk_i);
      check("override input", func_in_o[36], 1'b1);
      check("old input", func_in_o[22], 1'b0);
      write(SRC_CONFIG_STAGE, 5'h01, 1'b1, 6'h24, 1'b0);
      write(SRC_CONFIG_STAGE, 5'h07, 1'b1, 6'h2B, 1'b0);
      write(SRC_TARGET_BUS, 5'h06, 1'b0, 6'h00, 1'b0);
      write(SRC_CONFIG_STAGE, 5'h07, 1'b1, 6'h25, 1'b1);
      hub_attached_i = 1'b1;
      write(SRC_CONFIG_STAGE, 5'h06, 1'b0, 6'h00, 1'b0);
      write(SRC_TARGET_BUS, 5'h06, 1'b0, 6'h00, 1'b1);
      write(SRC_USB_COMMAND, 5'h1B, 1'b1, 6'h16, 1'b1);
      repeat (4) @(negedge mclk_i);
      check("restored input", func_in_o[22], 1'b1);
      results();
   end
endmodule : testbench
